//--- conv_ctrl_device.sv
// Converter control end: configuration, reference level, sequencer slot,
// power-down modes and software reset, driven from the parallel bus.
// Assumes strobes are synchronous to clk_i and active low.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_device (
    input wire logic clk_i, // 50 MHz clock
    input wire logic reset_i, // Synchronous active-high reset
    conv_link_if.device link, // Parallel bus
    output logic [1:0] input_pair_o, // Selected input pair
    output logic analog_on_o, // Analog bias enabled
    output logic converting_o, // Conversion running
    output logic [1:0] slot_pointer_o, // Sequence position
    output logic [9:0] ref_level_o, // Reference level
    output logic ref_off_o // Reference powered down
);
    import conv_ctrl_pkg::*;
    typedef enum logic [3:0] {IDLE = 4'h1, WAKE = 4'h2, CONV = 4'h4, SLEEP = 4'h8} cstate_t;
    logic [11:0] cfg_q, cfg_d, seq_q, seq_d;
    logic [9:0] ref_q, ref_d;
    logic [2:0] pend_q, pend_d;
    logic [1:0] sp_q, sp_d;
    logic store_q, fetch_q, trig_q, store_rise, fetch_fall, trig_fall;
    cstate_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, off_q, off_d;
    logic dozing_q, dozing_d, an_q, an_d, soft_rst_q, soft_rst_d;
    logic [11:0] rd_q, rd_d;
    logic oe_q, oe_d;
    logic [1:0] len;
    logic sleep_req;
    assign store_rise = link.store_n & ~store_q;
    assign fetch_fall = ~link.fetch_n & fetch_q;
    assign trig_fall = ~link.convert_trigger & trig_q;
    assign len = seq_q[SEQ_LEN_HI:SEQ_LEN_LO];
    assign sleep_req = cfg_q[DEEP_BIT] | cfg_q[NAP_BIT];
    assign link.dev_bus = rd_q;
    assign link.dev_bus_oe = oe_q;
    assign link.busy = (st_q == CONV);
    always_comb
    begin
        cfg_d = cfg_q;
        seq_d = seq_q;
        ref_d = ref_q;
        pend_d = pend_q;
        soft_rst_d = 1'b0;
        if (store_rise)
        begin
            pend_d = 3'h0;
            if (pend_q == SEL_REF_WR)
                ref_d = link.host_bus[9:0]; // RULE3 RULE16
            else if (pend_q == SEL_SEQ_WR)
                seq_d = {link.host_bus[11:2], seq_q[1:0]}; // RULE16
            else if (link.host_bus[GATE_HI:GATE_LO] == GATE_OPEN) // RULE17
            begin
                cfg_d = link.host_bus; // RULE7 RULE8 RULE15
                case (link.host_bus[SEL_HI:SEL_LO])
                    SEL_REF_WR: pend_d = SEL_REF_WR; // RULE2
                    SEL_REF_RD: pend_d = SEL_REF_RD; // RULE4
                    SEL_SEQ_WR: pend_d = SEL_SEQ_WR;
                    SEL_SEQ_RD: pend_d = SEL_SEQ_RD;
                    SEL_RESET: soft_rst_d = 1'b1; // RULE14
                    default: pend_d = 3'h0;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i | soft_rst_q)
        begin
            cfg_q <= CFG_RESET;
            seq_q <= SEQ_RESET;
            ref_q <= REF_RESET; // RULE6
            pend_q <= 3'h0;
        end
        else
        begin
            cfg_q <= cfg_d;
            seq_q <= seq_d;
            ref_q <= ref_d;
            pend_q <= pend_d;
        end
    end
    always_comb
    begin
        rd_d = rd_q;
        oe_d = 1'b0;
        if (~link.fetch_n)
        begin
            oe_d = 1'b1;
            if (fetch_fall)
            begin
                if (pend_q == SEL_REF_RD)
                    rd_d = {2'h0, ref_q}; // RULE5 RULE6
                else if (pend_q == SEL_SEQ_RD)
                    rd_d = {seq_q[11:2], sp_q}; // RULE1
                else
                    rd_d = cfg_q;
            end
        end
    end
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        sp_d = sp_q;
        off_d = off_q;
        dozing_d = dozing_q;
        an_d = cfg_q[DOZE_BIT]; // RULE12
        if (len == 2'h0)
            sp_d = 2'h0;
        else if (sp_q == 2'h0)
            sp_d = 2'h1;
        if (sleep_req)
        begin
            st_d = SLEEP; // RULE9
            // The wake count is loaded here: once the enable bit is cleared the mode is gone.
            cnt_d = cfg_q[DEEP_BIT] ? CNT_W'(DEEP_WAKE_CYC - 1) :
                CNT_W'(NAP_WAKE_CYC - 1); // RULE10 RULE11
            dozing_d = 1'b0;
            if (off_q != '0)
                off_d = off_q - 1'b1;
        end
        else
        begin
            case (st_q)
                IDLE:
                    if (trig_fall)
                    begin
                        st_d = dozing_q ? WAKE : CONV;
                        cnt_d = dozing_q ? CNT_W'(NAP_WAKE_CYC - 1) : CNT_W'(CONV_CYC - 1);
                    end
                    else if (dozing_q && off_q != '0)
                        off_d = off_q - 1'b1;
                WAKE:
                    if (cnt_q == '0)
                    begin
                        // Only an auto-doze trigger converts; leaving deep or nap just idles.
                        st_d = dozing_q ? CONV : IDLE; // RULE13 RULE11
                        dozing_d = 1'b0;
                        cnt_d = CNT_W'(CONV_CYC - 1);
                    end
                    else
                        cnt_d = cnt_q - 1'b1;
                CONV:
                    if (cnt_q == '0)
                    begin
                        st_d = IDLE;
                        if (len != 2'h0)
                            sp_d = (sp_q >= len) ? 2'h1 : sp_q + 2'h1; // RULE18
                        if (an_q)
                        begin
                            dozing_d = 1'b1; // RULE12
                            off_d = CNT_W'(NAP_OFF_CYC - 1);
                        end
                    end
                    else
                        cnt_d = cnt_q - 1'b1;
                SLEEP:
                    st_d = WAKE; // RULE8
                default: st_d = IDLE;
            endcase
        end
        if (sleep_req && st_q != SLEEP)
            // Two register stages lie between the store edge and the output, so start short.
            off_d = cfg_q[DEEP_BIT] ? CNT_W'(DEEP_OFF_CYC - 2) :
                CNT_W'(NAP_OFF_CYC - 2); // RULE10 RULE11
    end
    always_ff @(posedge clk_i)
    begin
        store_q <= reset_i ? 1'b1 : link.store_n;
        fetch_q <= reset_i ? 1'b1 : link.fetch_n;
        trig_q <= reset_i ? 1'b1 : link.convert_trigger;
        if (reset_i | soft_rst_q)
        begin
            st_q <= IDLE;
            cnt_q <= '0;
            sp_q <= 2'h0;
            off_q <= '0;
            dozing_q <= 1'b0;
            an_q <= 1'b0;
            rd_q <= 12'h000;
            oe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sp_q <= sp_d;
            off_q <= off_d;
            dozing_q <= dozing_d;
            an_q <= an_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
        end
        soft_rst_q <= reset_i ? 1'b0 : soft_rst_d;
        input_pair_o <= reset_i ? 2'h0 : cfg_q[CH_HI:CH_LO]; // RULE15
        analog_on_o <= reset_i ? 1'b1 : ~((st_q == SLEEP || dozing_q) && off_q == '0);
        converting_o <= reset_i ? 1'b0 : (st_d == CONV);
        slot_pointer_o <= reset_i ? 2'h0 : sp_q;
        ref_level_o <= reset_i ? REF_RESET : ref_q;
        ref_off_o <= reset_i ? 1'b0 : cfg_q[REFPD_BIT];
    end
endmodule
`default_nettype wire

//--- conv_ctrl_pkg.sv
// Shared constants for the converter control link: configuration word layout,
// access-select codes, reference level layout and power-down timing counts.
// Assumes a single 50 MHz clock shared by both ends.
// Functional notes
// RULE1: Two-bit slot position reads back, zero when off.
// RULE2: Reference load armed by gate 01, select 001.
// RULE3: Next store carries zero top bits, ten-bit value.
// RULE4: Read-back armed by gate 01, select 011.
// RULE5: Fetch strobe drives reference onto low ten bits.
// RULE6: Reference resets to all ones, top bits zero.
// RULE7: Deep and nap start at store strobe end.
// RULE8: Clearing enable bit leaves mode; config kept.
// RULE9: Entering deep or nap aborts running conversion.
// RULE10: Deep off within 2 us, back 1 us.
// RULE11: Nap off within 200 ns, back six clocks.
// RULE12: Auto-doze sleeps within 200 ns after conversion.
// RULE13: Auto-doze trigger wakes, converts six clocks later.
// RULE14: Select 101 resets device; host waits 20 ns.
// RULE15: Inputs chosen only by channel bits or sequencer.
// RULE16: Two-write settings apply at second strobe end.
// RULE17: Update gate 01 permits updates; others block.
// RULE18: Slot position advances, wraps at sequence length.
package conv_ctrl_pkg;
    localparam int CLK_MHZ = 50;
    localparam int BUS_W = 12;
    localparam int CH_HI = 11;
    localparam int CH_LO = 10;
    localparam int GATE_HI = 9;
    localparam int GATE_LO = 8;
    localparam int DEEP_BIT = 7;
    localparam int NAP_BIT = 6;
    localparam int DOZE_BIT = 5;
    localparam int REFPD_BIT = 4;
    localparam int SEL_HI = 2;
    localparam int SEL_LO = 0;
    localparam logic [1:0] GATE_OPEN = 2'h1;
    localparam logic [2:0] SEL_REF_WR = 3'h1;
    localparam logic [2:0] SEL_REF_RD = 3'h3;
    localparam logic [2:0] SEL_SEQ_WR = 3'h4;
    localparam logic [2:0] SEL_RESET = 3'h5;
    localparam logic [2:0] SEL_SEQ_RD = 3'h6;
    localparam logic [9:0] REF_RESET = 10'h3ff;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam logic [11:0] SEQ_RESET = 12'h000;
    localparam int SEQ_LEN_HI = 9;
    localparam int SEQ_LEN_LO = 8;
    localparam int DEEP_OFF_NS = 2000;
    localparam int DEEP_WAKE_NS = 1000;
    localparam int NAP_OFF_NS = 200;
    localparam int RESET_GAP_NS = 20;
    localparam int DEEP_OFF_CYC = DEEP_OFF_NS * CLK_MHZ / 1000;
    localparam int DEEP_WAKE_CYC = (DEEP_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int NAP_OFF_CYC = NAP_OFF_NS * CLK_MHZ / 1000;
    localparam int NAP_WAKE_CYC = 6;
    localparam int CONV_CYC = 16;
    localparam int RESET_GAP_CYC = (RESET_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
endpackage

//--- conv_link_if.sv
// Parallel bus between host controller and converter control logic.
// Assumes the testbench resolves the bidirectional bus from the two enables.
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
    logic store_n;
    logic fetch_n;
    logic convert_trigger;
    logic [11:0] host_bus;
    logic host_bus_oe;
    logic [11:0] dev_bus;
    logic dev_bus_oe;
    logic busy;
    modport device (input store_n, fetch_n, convert_trigger, host_bus, host_bus_oe,
                    output dev_bus, dev_bus_oe, busy);
    modport host (output store_n, fetch_n, convert_trigger, host_bus, host_bus_oe,
                  input dev_bus, dev_bus_oe, busy);
endinterface
`default_nettype wire

//--- conv_ctrl_host.sv
// Host end: turns single commands into store and fetch strobe pulses.
// Assumes one command at a time; busy_o stays high until a store or fetch is done, and stays low for a convert.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_host (
    input wire logic clk_i, // 50 MHz clock
    input wire logic reset_i, // Synchronous active-high reset
    conv_link_if.host link, // Parallel bus
    input wire logic wr_i, // Store word pulse
    input wire logic rd_i, // Fetch word pulse
    input wire logic conv_i, // Convert pulse
    input wire logic [11:0] wdata_i, // Word to store
    output logic [11:0] rdata_o, // Fetched word
    output logic rvalid_o, // Fetched word valid pulse
    output logic busy_o // Command in progress
);
    import conv_ctrl_pkg::*;
    typedef enum logic [3:0] {H_IDLE = 4'h1, H_WR = 4'h2, H_RD = 4'h4, H_GAP = 4'h8} hstate_t;
    hstate_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [11:0] bus_q, bus_d, rdata_d;
    logic store_d, fetch_d, trig_d, oe_d, rvalid_d, rst_pend_q, rst_pend_d;
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        bus_d = bus_q;
        store_d = 1'b1;
        fetch_d = 1'b1;
        trig_d = 1'b1;
        oe_d = 1'b0;
        rvalid_d = 1'b0;
        rdata_d = rdata_o;
        rst_pend_d = rst_pend_q;
        case (st_q)
            H_IDLE:
                if (wr_i)
                begin
                    st_d = H_WR;
                    bus_d = wdata_i; // RULE2 RULE3 RULE4
                    cnt_d = 3'h1;
                    store_d = 1'b0;
                    oe_d = 1'b1;
                    rst_pend_d = wdata_i[GATE_HI:GATE_LO] == GATE_OPEN &&
                        wdata_i[SEL_HI:SEL_LO] == SEL_RESET;
                end
                else if (rd_i)
                begin
                    st_d = H_RD;
                    cnt_d = 3'h2;
                    fetch_d = 1'b0;
                end
                else if (conv_i)
                    trig_d = 1'b0;
            H_WR:
            begin
                oe_d = 1'b1;
                if (cnt_q == 3'h0)
                begin
                    st_d = H_GAP;
                    cnt_d = rst_pend_q ? 3'(RESET_GAP_CYC + 2) : 3'h1; // RULE14
                end
                else
                begin
                    store_d = 1'b0;
                    cnt_d = cnt_q - 3'h1;
                end
            end
            H_RD:
                if (cnt_q == 3'h0)
                begin
                    rdata_d = link.dev_bus; // RULE5
                    rvalid_d = 1'b1;
                    st_d = H_GAP;
                    cnt_d = 3'h1;
                end
                else
                begin
                    fetch_d = 1'b0;
                    cnt_d = cnt_q - 3'h1;
                end
            H_GAP:
                if (cnt_q == 3'h0)
                begin
                    st_d = H_IDLE;
                    rst_pend_d = 1'b0;
                end
                else
                    cnt_d = cnt_q - 3'h1;
            default: st_d = H_IDLE;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_q <= H_IDLE;
            cnt_q <= 3'h0;
            bus_q <= 12'h000;
            link.store_n <= 1'b1;
            link.fetch_n <= 1'b1;
            link.convert_trigger <= 1'b1;
            link.host_bus_oe <= 1'b0;
            rdata_o <= 12'h000;
            rvalid_o <= 1'b0;
            busy_o <= 1'b0;
            rst_pend_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bus_q <= bus_d;
            link.store_n <= store_d;
            link.fetch_n <= fetch_d;
            link.convert_trigger <= trig_d;
            link.host_bus_oe <= oe_d;
            rdata_o <= rdata_d;
            rvalid_o <= rvalid_d;
            busy_o <= (st_d != H_IDLE);
            rst_pend_q <= rst_pend_d;
        end
    end
    assign link.host_bus = bus_q;
endmodule
`default_nettype wire

//--- conv_link_chk.sv
// Checker for the converter link: strobes, read-back data, busy during nap, conversion length and reset gap.
// Assumes it watches the interface that joins the host end to the device end.
`timescale 1ns/1ps
`default_nettype none
module conv_link_chk (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic store_n, // Store strobe
    input wire logic fetch_n, // Fetch strobe
    input wire logic convert_trigger, // Convert trigger
    input wire logic [11:0] host_bus, // Host data
    input wire logic host_bus_oe, // Host drive
    input wire logic [11:0] dev_bus, // Device data
    input wire logic dev_bus_oe, // Device drive
    input wire logic busy // Conversion busy
);
    import conv_ctrl_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic [2:0] arm_q, arm_d;
    logic [9:0] ref_q, ref_d;
    logic [7:0] cnt_q, cnt_d;
    logic nap_q, nap_d, st_q;
    logic [2:0] sel;
    assign sel = host_bus[SEL_HI:SEL_LO];
    // A shadow of the reference and the pending arm, updated at each store end.
    always_comb
    begin
        arm_d = arm_q;
        ref_d = ref_q;
        nap_d = nap_q;
        cnt_d = busy ? cnt_q + 8'h1 : 8'h0;
        if (store_n && !st_q)
        begin
            arm_d = 3'h0;
            if (arm_q == SEL_REF_WR)
                ref_d = host_bus[9:0];
            else if (arm_q != SEL_SEQ_WR && host_bus[GATE_HI:GATE_LO] == GATE_OPEN)
            begin
                if (sel == SEL_RESET)
                begin
                    ref_d = REF_RESET;
                    nap_d = 1'b0;
                end
                else
                begin
                    // Arming words carry a full configuration word as well.
                    nap_d = host_bus[NAP_BIT];
                    if (sel inside {SEL_REF_WR, SEL_REF_RD, SEL_SEQ_WR, SEL_SEQ_RD})
                        arm_d = sel;
                end
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        arm_q <= reset_i ? 3'h0 : arm_d;
        ref_q <= reset_i ? REF_RESET : ref_d;
        nap_q <= reset_i ? 1'b0 : nap_d;
        cnt_q <= reset_i ? 8'h0 : cnt_d;
        st_q <= reset_i ? 1'b1 : store_n;
    end
    a_read_ref_value: assert property (dev_bus_oe && arm_q == SEL_REF_RD |-> dev_bus == {2'h0, ref_q})
        else $error("reference read-back wrong");
    a_oe_follows_fetch: assert property ($fell(fetch_n) |=> dev_bus_oe)
        else $error("device drive late");
    a_oe_release: assert property ($rose(fetch_n) |=> !dev_bus_oe)
        else $error("device drive held");
    a_read_data_hold: assert property (dev_bus_oe && $past(dev_bus_oe) |-> $stable(dev_bus))
        else $error("read data moved");
    a_store_drives_bus: assert property (!store_n |-> host_bus_oe)
        else $error("store without bus drive");
    a_single_strobe: assert property (!store_n |-> fetch_n)
        else $error("both strobes low");
    a_nap_no_busy: assert property (nap_q && $past(nap_q, 2) |-> !busy)
        else $error("busy while napping");
    a_conv_bound: assert property (cnt_q <= 8'(CONV_CYC))
        else $error("conversion too long");
    a_reset_gap: assert property ($rose(store_n) && arm_q == 3'h0 && sel == SEL_RESET
        && host_bus[GATE_HI:GATE_LO] == GATE_OPEN |-> (store_n && fetch_n)[*2])
        else $error("access too soon after reset");
endmodule
`default_nettype wire

//--- testbench.sv
// Testbench joining host and device ends through the link interface.
// Assumes a 50 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import conv_ctrl_pkg::*;
    logic clk_i, reset_i, wr_i, rd_i, conv_i, hi;
    logic [11:0] wdata_i, rdata_o, seen;
    logic rvalid_o, busy_o, analog_on_o, converting_o, ref_off_o;
    logic [1:0] input_pair_o, slot_pointer_o;
    logic [9:0] ref_level_o;
    int n_errors, checks, n, norm, len;
    conv_link_if u_conv_link_if();
    conv_ctrl_device u_conv_ctrl_device (.clk_i(clk_i), .reset_i(reset_i), .link(u_conv_link_if),
        .input_pair_o(input_pair_o), .analog_on_o(analog_on_o), .converting_o(converting_o),
        .slot_pointer_o(slot_pointer_o), .ref_level_o(ref_level_o), .ref_off_o(ref_off_o));
    conv_ctrl_host u_conv_ctrl_host (.clk_i(clk_i), .reset_i(reset_i), .link(u_conv_link_if),
        .wr_i(wr_i), .rd_i(rd_i), .conv_i(conv_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .busy_o(busy_o));
    conv_link_chk u_conv_link_chk (.clk_i(clk_i), .reset_i(reset_i),
        .store_n(u_conv_link_if.store_n), .fetch_n(u_conv_link_if.fetch_n),
        .convert_trigger(u_conv_link_if.convert_trigger), .host_bus(u_conv_link_if.host_bus),
        .host_bus_oe(u_conv_link_if.host_bus_oe), .dev_bus(u_conv_link_if.dev_bus),
        .dev_bus_oe(u_conv_link_if.dev_bus_oe), .busy(u_conv_link_if.busy));
    task automatic check(string name, logic [11:0] seen_v, logic [11:0] exp_v);
        checks++;
        if (seen_v !== exp_v)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input int which, input logic [11:0] d);
        @(posedge clk_i);
        wr_i <= (which == 0);
        rd_i <= (which == 1);
        conv_i <= (which == 2);
        wdata_i <= d;
        @(posedge clk_i);
        {wr_i, rd_i, conv_i} <= 3'h0;
        #1;
    endtask
    // Every wait is bounded; running out of cycles ends the run as a failure.
    task automatic idle();
        for (n = 0; n < 100 && busy_o !== 1'b0; n++)
            tick();
        if (n == 100)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic wr(logic [11:0] d);
        pulse(0, d);
        tick();
        idle();
    endtask
    task automatic rd(output logic [11:0] d);
        pulse(1, 12'h000);
        for (n = 0; n < 20 && rvalid_o !== 1'b1; n++)
            tick();
        if (n == 20)
        begin
            n_errors++;
            give_verdict();
        end
        d = rdata_o;
        idle();
    endtask
    task automatic conv(output int l);
        pulse(2, 12'h000);
        hi = 1'b0;
        for (l = 0; l < 60 && !(hi && u_conv_link_if.busy === 1'b0); l++)
        begin
            tick();
            hi = hi | (u_conv_link_if.busy === 1'b1);
        end
        if (l == 60)
        begin
            n_errors++;
            give_verdict();
        end
        // One more edge lets the registered slot position settle.
        tick();
    endtask
    task automatic wait_on(string name, logic lvl, int lim);
        for (n = 0; n < lim && analog_on_o !== lvl; n++)
            tick();
        check(name, 12'(analog_on_o), 12'(lvl));
        if (analog_on_o !== lvl)
            give_verdict();
    endtask
    function automatic logic [11:0] cfg(logic [1:0] ch, logic [3:0] pd, logic [2:0] sel);
        return {ch, GATE_OPEN, pd, 1'b0, sel};
    endfunction
    task automatic t_ref();
        tick();
        check("ref_reset", 12'(ref_level_o), 12'h3ff);
        check("slot_off", 12'(slot_pointer_o), 12'h000);
        wr(cfg(2'h0, 4'h0, SEL_REF_RD));
        rd(seen);
        check("ref_read_reset", seen, 12'h3ff);
        wr(cfg(2'h0, 4'h0, SEL_REF_WR));
        check("ref_after_arm", 12'(ref_level_o), 12'h3ff);
        wr(12'h2a5);
        check("ref_loaded", 12'(ref_level_o), 12'h2a5);
        wr(cfg(2'h0, 4'h0, SEL_REF_RD));
        rd(seen);
        check("ref_read", seen, 12'h2a5);
        for (int g = 0; g < 4; g += 3)
        begin
            wr({2'h0, 2'(g), 5'h00, SEL_REF_WR});
            wr(12'h0aa);
            check("gate_shut", 12'(ref_level_o), 12'h2a5);
        end
        $display("test ref done");
    endtask
    task automatic t_chan();
        for (int i = 0; i < 4; i++)
        begin
            wr(cfg(2'(i), 4'h0, 3'h0));
            check("input_pair", 12'(input_pair_o), 12'(i));
        end
        wr(cfg(2'h3, 4'h1, 3'h0));
        check("ref_off", 12'(ref_off_o), 12'h001);
        wr(cfg(2'h3, 4'h1, SEL_RESET));
        repeat (3) tick();
        check("soft_ref", 12'(ref_level_o), 12'h3ff);
        check("soft_cfg", 12'(input_pair_o), 12'h000);
        check("soft_ref_off", 12'(ref_off_o), 12'h000);
        $display("test chan done");
    endtask
    task automatic t_seq();
        wr(cfg(2'h0, 4'h0, SEL_SEQ_WR));
        wr(12'h300);
        tick();
        check("slot_first", 12'(slot_pointer_o), 12'h001);
        wr(cfg(2'h0, 4'h0, SEL_SEQ_RD));
        rd(seen);
        check("seq_read", seen, 12'h301);
        for (int i = 2; i < 6; i++)
        begin
            conv(len);
            check("slot_next", 12'(slot_pointer_o), 12'((i - 1) % 3 + 1));
        end
        norm = len;
        $display("test seq done");
    endtask
    task automatic t_sleep();
        pulse(2, 12'h000);
        tick();
        check("conv_run", 12'(converting_o), 12'h001);
        wr(cfg(2'h2, 4'h4, 3'h0));
        tick();
        check("nap_abort", 12'(converting_o), 12'h000);
        wait_on("nap_off", 1'b0, NAP_OFF_CYC + 3);
        check("cfg_kept", 12'(input_pair_o), 12'h002);
        pulse(2, 12'h000);
        repeat (4) tick();
        check("nap_refuse", 12'(converting_o), 12'h000);
        wr(cfg(2'h2, 4'h0, 3'h0));
        wait_on("nap_wake", 1'b1, NAP_WAKE_CYC + 3);
        wr(cfg(2'h2, 4'h8, 3'h0));
        wait_on("deep_off", 1'b0, DEEP_OFF_CYC + 3);
        wr(cfg(2'h2, 4'h0, 3'h0));
        wait_on("deep_wake", 1'b1, DEEP_WAKE_CYC + 3);
        repeat (DEEP_WAKE_CYC) tick();
        wr(cfg(2'h2, 4'h2, 3'h0));
        conv(len);
        wait_on("doze_off", 1'b0, NAP_OFF_CYC + 3);
        conv(len);
        check("doze_wake", 12'(len - norm), 12'(NAP_WAKE_CYC));
        $display("test sleep done");
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        {reset_i, wr_i, rd_i, conv_i} = 4'h8;
        wdata_i = 12'h000;
        n_errors = 0;
        checks = 0;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        t_ref();
        t_chan();
        t_seq();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
